// ---- logic/pmc_defs.vh ----
// constants for the power management capability block
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// register byte offsets
`define PMC_OFS_CTRL 8'h00
`define PMC_OFS_CAP 8'h08
`define PMC_OFS_STAT 8'h10
`define PMC_OFS_MASK 8'h14
`define PMC_OFS_CFG 8'h18

// capability register bit positions
`define PMC_CAP_WAKE_D3COLD 15
`define PMC_CAP_WAKE_D3HOT 14
`define PMC_CAP_WAKE_D2 13
`define PMC_CAP_WAKE_D1 12
`define PMC_CAP_WAKE_D0 11
`define PMC_CAP_D2_SUPPORT_CFG 10
`define PMC_CAP_D1_SUPPORT_CFG 9
`define PMC_CAP_BUSW 0

// bit positions inside the loaded configuration word
`define PMC_EE_WAKE_D2 5
`define PMC_EE_WAKE_D1 4
`define PMC_EE_D2_SUPPORT_CFG 3
`define PMC_EE_D1_SUPPORT_CFG 2
`define PMC_EE_NARROW 0

// control register fields
`define PMC_CTRL_PS_LO 0
`define PMC_CTRL_PS_HI 1
`define PMC_CTRL_WEN 8
`define PMC_CTRL_WAKE 15

// power state codes
`define PMC_PS_D0 2'h0
`define PMC_PS_D1 2'h1
`define PMC_PS_D2 2'h2
`define PMC_PS_D3HOT 2'h3

// status and mask bits
`define PMC_ST_LOAD 0
`define PMC_ST_WAKE 1

// reset values
`define PMC_PS_RST 2'h0
`define PMC_MASK_RST 2'h0
`define PMC_WORD_RST 16'h0000

// settle time after the pin synchroniser, in clock cycles
`define PMC_SETTLE_CYC 4'h4

// bus answers
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_DECERR 2'h3

`endif

// ---- logic/pmc_sync3.v ----
// three-stage pin synchroniser that accepts a level once stages agree
`timescale 1ns/10ps
`default_nettype none

module pmc_sync3 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // asynchronous pins and their settled copy
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] q
);

  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // s1 feeds s2 only; a glitch must survive two stages to count
      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          s1[i] <= din[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            q[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- logic/pmc_top.v ----
// power management capability register bank with axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defs.vh"

//Contract
// RL1: the capability register sits read-only at 0x08 and its loadable bits fill from the configuration word when the eeprom pin is high.
// RL2: bit 15 always reads 0, so no wake event in cold D3.
// RL3: bit 14 always reads 1, so the wake event may be raised in hot D3.
// RL4: with bit 13 set, state D2 and wake enable set, wake-up signals raise the wake event, and never otherwise in D2.
// RL5: bit 13 comes from the D2 wake bit of word 0x6 and reads 0 with no eeprom.
// RL6: with bit 12 set, state D1 and wake enable set, wake-up signals raise the wake event, and never otherwise in D1.
// RL7: bit 12 comes from the D1 wake bit of word 0x6 and reads 0 with no eeprom.
// RL8: bit 11 reads 0 and the wake event is never raised in D0.
// RL9: bit 10 reports D2 support from word 0x6, 0 with no eeprom.
// RL10: bit 9 reports D1 support from word 0x6, 0 with no eeprom.
// RL11: on the 16-bit variant bit 0 reads 1 for a 16-bit bus and 0 for an 8-bit bus.
// RL12: bit 0 is meaningful only with the eeprom enabled, taken from its narrow async setting.
// RL13: with the eeprom pin high the configuration is loaded right after reset.
// RL14: writes to the capability register do nothing and bits 8 to 1 read 0.
module pmc_top #(
  parameter BUS16_VARIANT = 1
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // axi4-lite write address
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read address
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  // axi4-lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // eeprom strap pin and configuration loader
  input wire eepromEnablePin,
  output reg cfgLoadReq,
  input wire cfgWordValid,
  input wire [15:0] cfgWord,
  // wake-up source and wake event pin
  input wire wakeSignal,
  output reg wakeEventOutN,
  // interrupt
  output reg irq
);

  localparam ST_SETTLE = 4'b0001;
  localparam ST_REQ = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_DONE = 4'b1000;

  // synchronised strap
  wire eepromPinSync;

  pmc_sync3 #(
    .WIDTH(1)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .din(eepromEnablePin),
    .q(eepromPinSync)
  );

  // loader state
  reg [3:0] loadState;
  reg [3:0] next_loadState;
  reg [3:0] settleCnt;
  reg eeUsed;
  reg loadDone;
  reg [15:0] eeWord;
  wire loadEvent;

  // control, status and mask
  reg [1:0] powerState;
  reg wakeEnable;
  reg wakeLatched;
  reg [1:0] status;
  reg [1:0] mask;
  reg [1:0] next_status;
  reg next_wakeLatched;

  // write channel holding
  reg awHeld;
  reg wHeld;
  reg [7:0] awAddrHeld;
  reg [31:0] wDataHeld;
  reg [3:0] wStrbHeld;
  reg next_awHeld;
  reg next_wHeld;
  reg next_bvalid;

  wire awTake;
  wire wTake;
  wire doWrite;
  wire arTake;
  wire [7:0] wrAddr;
  wire [7:0] rdAddr;
  wire [15:0] capValue;
  wire busWidthBit;
  reg wakeAllowed;
  wire wakeRise;
  wire wakeClear;
  wire statusRead;
  reg [31:0] readMux;
  reg readHit;

  // load sequence: settle, request, wait for the word
  assign loadEvent = (loadState == ST_WAIT && cfgWordValid) ||
    (loadState == ST_SETTLE && settleCnt == `PMC_SETTLE_CYC &&
    !eepromPinSync);

  always @* begin
    next_loadState = loadState;
    case (loadState)
      ST_SETTLE: begin
        if (settleCnt == `PMC_SETTLE_CYC) begin
          if (eepromPinSync) begin
            next_loadState = ST_REQ; // [RL13]
          end else begin
            next_loadState = ST_DONE;
          end
        end
      end
      ST_REQ: begin
        next_loadState = ST_WAIT;
      end
      ST_WAIT: begin
        if (cfgWordValid) begin
          next_loadState = ST_DONE;
        end
      end
      ST_DONE: begin
        next_loadState = ST_DONE;
      end
      default: begin
        next_loadState = ST_SETTLE;
      end
    endcase
  end

  // strap is taken only after release, through the synchroniser
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      loadState <= ST_SETTLE;
      settleCnt <= 4'h0;
      eeUsed <= 1'b0;
      loadDone <= 1'b0;
      eeWord <= `PMC_WORD_RST;
      cfgLoadReq <= 1'b0;
    end else begin
      loadState <= next_loadState;
      cfgLoadReq <= (next_loadState == ST_REQ);
      if (loadState == ST_SETTLE && settleCnt != `PMC_SETTLE_CYC) begin
        settleCnt <= settleCnt + 4'h1;
      end
      if (loadState == ST_SETTLE && settleCnt == `PMC_SETTLE_CYC) begin
        eeUsed <= eepromPinSync;
      end
      if (loadState == ST_WAIT && cfgWordValid) begin
        eeWord <= cfgWord; // [RL1]
      end
      if (loadEvent) begin
        loadDone <= 1'b1;
      end
    end
  end

  // capability word; loaded bits are gated so no eeprom reads as 0
  assign busWidthBit = (BUS16_VARIANT != 0) && eeUsed &&
    !eeWord[`PMC_EE_NARROW]; // [RL11] [RL12]

  assign capValue[`PMC_CAP_WAKE_D3COLD] = 1'b0; // [RL2]
  assign capValue[`PMC_CAP_WAKE_D3HOT] = 1'b1; // [RL3]
  assign capValue[`PMC_CAP_WAKE_D2] = eeUsed &
    eeWord[`PMC_EE_WAKE_D2]; // [RL5]
  assign capValue[`PMC_CAP_WAKE_D1] = eeUsed &
    eeWord[`PMC_EE_WAKE_D1]; // [RL7]
  assign capValue[`PMC_CAP_WAKE_D0] = 1'b0; // [RL8]
  assign capValue[`PMC_CAP_D2_SUPPORT_CFG] = eeUsed &
    eeWord[`PMC_EE_D2_SUPPORT_CFG]; // [RL9]
  assign capValue[`PMC_CAP_D1_SUPPORT_CFG] = eeUsed &
    eeWord[`PMC_EE_D1_SUPPORT_CFG]; // [RL10]
  assign capValue[8:1] = 8'h00; // [RL14]
  assign capValue[`PMC_CAP_BUSW] = busWidthBit;

  // wake gating per power state
  always @* begin
    case (powerState)
      `PMC_PS_D0: wakeAllowed = 1'b0; // [RL8]
      `PMC_PS_D1: wakeAllowed = capValue[`PMC_CAP_WAKE_D1]; // [RL6]
      `PMC_PS_D2: wakeAllowed = capValue[`PMC_CAP_WAKE_D2]; // [RL4]
      `PMC_PS_D3HOT: wakeAllowed = capValue[`PMC_CAP_WAKE_D3HOT]; // [RL3]
      default: wakeAllowed = 1'b0;
    endcase
  end

  assign wakeRise = wakeSignal & wakeEnable & wakeAllowed &
    ~wakeLatched; // [RL4] [RL6]

  // bus handshakes
  assign awTake = awvalid & awready;
  assign wTake = wvalid & wready;
  assign arTake = arvalid & arready;
  assign doWrite = awHeld & wHeld & ~bvalid;
  assign wrAddr = {awAddrHeld[7:2], 2'b00};
  assign rdAddr = {araddr[7:2], 2'b00};
  assign wakeClear = doWrite && wrAddr == `PMC_OFS_CTRL &&
    wStrbHeld[1] && wDataHeld[`PMC_CTRL_WAKE];
  assign statusRead = arTake && rdAddr == `PMC_OFS_STAT;

  always @* begin
    next_awHeld = doWrite ? 1'b0 : (awHeld | awTake);
    next_wHeld = doWrite ? 1'b0 : (wHeld | wTake);
    next_bvalid = doWrite | (bvalid & ~bready);
  end

  // event set wins over clear, both for the pin and for status
  always @* begin
    next_wakeLatched = (wakeLatched & ~wakeClear) | wakeRise;
    next_status = statusRead ? 2'b00 : status;
    next_status[`PMC_ST_LOAD] = next_status[`PMC_ST_LOAD] | loadEvent;
    next_status[`PMC_ST_WAKE] = next_status[`PMC_ST_WAKE] | wakeRise;
  end

  // read decode
  always @* begin
    readMux = 32'h0000_0000;
    readHit = 1'b1;
    case (rdAddr)
      `PMC_OFS_CTRL: begin
        readMux[`PMC_CTRL_PS_HI:`PMC_CTRL_PS_LO] = powerState;
        readMux[`PMC_CTRL_WEN] = wakeEnable;
        readMux[`PMC_CTRL_WAKE] = wakeLatched;
      end
      `PMC_OFS_CAP: begin
        readMux[15:0] = capValue; // [RL1]
      end
      `PMC_OFS_STAT: begin
        readMux[1:0] = status;
      end
      `PMC_OFS_MASK: begin
        readMux[1:0] = mask;
      end
      `PMC_OFS_CFG: begin
        readMux[0] = loadDone;
        readMux[1] = eeUsed;
        readMux[31:16] = eeWord;
      end
      default: begin
        readHit = 1'b0;
      end
    endcase
  end

  // write channels and response
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld <= 32'h0000_0000;
      wStrbHeld <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `PMC_RESP_OKAY;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      bvalid <= next_bvalid;
      // one write at a time: both channels stall until the answer goes
      awready <= ~next_awHeld & ~next_bvalid;
      wready <= ~next_wHeld & ~next_bvalid;
      if (awTake) begin
        awAddrHeld <= awaddr;
      end
      if (wTake) begin
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
      end
      if (doWrite) begin
        case (wrAddr)
          `PMC_OFS_CTRL, `PMC_OFS_CAP, `PMC_OFS_STAT, `PMC_OFS_MASK,
          `PMC_OFS_CFG: bresp <= `PMC_RESP_OKAY; // [RL14]
          default: bresp <= `PMC_RESP_DECERR;
        endcase
      end
    end
  end

  // software state; the capability offset has no write path
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      powerState <= `PMC_PS_RST;
      wakeEnable <= 1'b0;
      mask <= `PMC_MASK_RST;
    end else if (doWrite) begin
      if (wrAddr == `PMC_OFS_CTRL && wStrbHeld[0]) begin
        powerState <= wDataHeld[`PMC_CTRL_PS_HI:`PMC_CTRL_PS_LO];
      end
      if (wrAddr == `PMC_OFS_CTRL && wStrbHeld[1]) begin
        wakeEnable <= wDataHeld[`PMC_CTRL_WEN];
      end
      if (wrAddr == `PMC_OFS_MASK && wStrbHeld[0]) begin
        mask <= wDataHeld[1:0];
      end
    end
  end

  // read channel
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PMC_RESP_OKAY;
    end else if (arTake) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= readMux;
      rresp <= readHit ? `PMC_RESP_OKAY : `PMC_RESP_DECERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // wake pin, status and interrupt
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wakeLatched <= 1'b0;
      status <= 2'b00;
      wakeEventOutN <= 1'b1;
      irq <= 1'b0;
    end else begin
      wakeLatched <= next_wakeLatched;
      status <= next_status;
      // pin follows the latch so it stays glitch free
      wakeEventOutN <= ~next_wakeLatched; // [RL4] [RL6] [RL8]
      irq <= |(next_status & mask);
    end
  end

endmodule

`default_nettype wire

// ---- tb/pmc_chk.sv ----
// assertions on the capability bank ports
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defs.vh"
module pmc_chk #(
  parameter BUS16_VARIANT = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // loader and wake
  input wire logic eepromEnablePin,
  input wire logic cfgLoadReq,
  input wire logic cfgWordValid,
  input wire logic [15:0] cfgWord,
  input wire logic wakeSignal,
  input wire logic wakeEventOutN
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [1:0] ps;
  logic en, ld, capRd, wOk;
  logic [15:0] w;
  logic [7:0] ra;
  // ctrl tracking assumes address and data taken at one edge
  assign wOk = awvalid && awready && wvalid && wready;
  assign capRd = rvalid && ra == `PMC_OFS_CAP;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ps <= 2'h0;
      en <= 1'b0;
      ld <= 1'b0;
      w <= 16'h0000;
      ra <= 8'h00;
    end else begin
      if (wOk && awaddr == `PMC_OFS_CTRL) begin
        ps <= wdata[1:0];
        en <= wdata[8];
      end
      if (cfgWordValid) begin
        w <= cfgWord;
        ld <= 1'b1;
      end
      if (arvalid && arready) ra <= araddr;
    end
  end
  property p_cap_fixed;
    capRd |-> rdata[15:14] == 2'h1 && rdata[11] == 1'b0 && rdata[8:1] == 8'h00;
  endproperty
  a_cap_fixed: assert property (p_cap_fixed)
    else $error("capability fixed bits wrong");
  property p_cap_load;
    capRd |-> {rdata[13:12], rdata[10:9]} == (ld ? {w[5:4], w[3:2]} : 4'h0);
  endproperty
  a_cap_load: assert property (p_cap_load)
    else $error("capability loaded bits wrong");
  property p_busw;
    capRd |-> rdata[0] == (BUS16_VARIANT != 0 && ld && !w[0]);
  endproperty
  a_busw: assert property (p_busw)
    else $error("bus width bit wrong");
  property p_no_d0;
    $fell(wakeEventOutN) |-> $past(ps) != `PMC_PS_D0 && $past(en);
  endproperty
  a_no_d0: assert property (p_no_d0)
    else $error("wake event in D0 or disabled");
  property p_d1;
    $fell(wakeEventOutN) && $past(ps) == `PMC_PS_D1 |-> w[4] && ld;
  endproperty
  a_d1: assert property (p_d1)
    else $error("wake event in D1 without capability");
  property p_d2;
    $fell(wakeEventOutN) && $past(ps) == `PMC_PS_D2 |-> w[5] && ld;
  endproperty
  a_d2: assert property (p_d2)
    else $error("wake event in D2 without capability");
  property p_wake_go;
    wakeSignal && en && (ps == `PMC_PS_D3HOT || ps == `PMC_PS_D1 && w[4] ||
      ps == `PMC_PS_D2 && w[5]) |=> !wakeEventOutN;
  endproperty
  a_wake_go: assert property (p_wake_go)
    else $error("wake event missing");
  property p_wr_resp;
    wOk |=> !bvalid ##1 bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response timing wrong");
  property p_rd_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data not held");
  property p_req;
    cfgLoadReq |-> eepromEnablePin;
  endproperty
  a_req: assert property (p_req)
    else $error("load requested without memory");
endmodule
bind pmc_top pmc_chk #(.BUS16_VARIANT(BUS16_VARIANT)) u_chk (
  .clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .eepromEnablePin(eepromEnablePin), .cfgLoadReq(cfgLoadReq),
  .cfgWordValid(cfgWordValid), .cfgWord(cfgWord),
  .wakeSignal(wakeSignal), .wakeEventOutN(wakeEventOutN)
);
`default_nettype wire

// ---- tb/pmc_ee_model.sv ----
// serial configuration memory model answering load requests
`timescale 1ns/10ps
`default_nettype none
module pmc_ee_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // load handshake
  input wire logic cfgLoadReq,
  output logic cfgWordValid,
  output logic [15:0] cfgWord,
  // stored word and answer delay
  input wire logic [15:0] word,
  input wire logic [3:0] dly
);
  logic busy;
  logic [3:0] cnt;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      cfgWordValid <= 1'b0;
      cfgWord <= 16'h0000;
    end else begin
      cfgWordValid <= 1'b0;
      // word only valid in its pulse, so scramble it otherwise
      cfgWord <= ~cfgWord;
      if (cfgLoadReq) begin
        busy <= 1'b1;
        cnt <= dly;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        cfgWordValid <= 1'b1;
        cfgWord <= word;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// bus-level test of the capability bank and wake logic
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defs.vh"
module testbench;
  logic clock = 0, nrst = 0, pin = 0, wake = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, req, vld, wakeN, irq;
  logic [1:0] bresp, rresp, r, br;
  logic [15:0] eeWord = 0, cw, cap;
  logic [3:0] eeDly = 0;
  logic perm;
  integer numErrors = 0, testsRun = 0, cyc = 0, c, s, n, rdly = 0;
  pmc_top DUT (.clock(clock), .nrst(nrst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .eepromEnablePin(pin), .cfgLoadReq(req), .cfgWordValid(vld),
    .cfgWord(cw), .wakeSignal(wake), .wakeEventOutN(wakeN), .irq(irq));
  pmc_ee_model ee (.clock(clock), .nrst(nrst), .cfgLoadReq(req),
    .cfgWordValid(vld), .cfgWord(cw), .word(eeWord), .dly(eeDly));
  initial begin
    forever #5 clock = ~clock;
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      numErrors = numErrors + 1;
      finish_test;
    end
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    begin
      testsRun = testsRun + 1;
      if (seen !== e) begin
        numErrors = numErrors + 1;
        $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    integer k, f;
    begin
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      k = 0;
      f = 0;
      while (!f && k < 50) begin
        @(posedge clock);
        k = k + 1;
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) begin
          bready <= 1'b0;
          br = bresp;
          f = 1;
        end
      end
      if (!f) numErrors = numErrors + 1;
      @(posedge clock);
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    integer k, f;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      // a late rready makes the slave hold its answer
      rready <= (rdly == 0);
      k = 0;
      f = 0;
      while (!f && k < 50) begin
        @(posedge clock);
        k = k + 1;
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid && rready) begin
          rready <= 1'b0;
          v = rdata;
          rr = rresp;
          f = 1;
        end else if (k >= rdly) begin
          rready <= 1'b1;
        end
      end
      if (!f) numErrors = numErrors + 1;
      @(posedge clock);
    end
  endtask
  initial begin
    for (c = 0; c < 3; c = c + 1) begin
      // reset again per strap setting; strap is read once after reset
      nrst <= 1'b0;
      pin <= (c != 1);
      eeWord <= (c == 2) ? 16'h0015 : 16'h003C;
      eeDly <= 4'(c * 3);
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      d = 0;
      n = 0;
      while (d[0] !== 1'b1 && n < 40) begin
        rd(`PMC_OFS_CFG, d, r);
        n = n + 1;
      end
      check("cfg", d, c == 1 ? 32'h0000_0001 : {eeWord, 16'h0003});
      cap = c == 0 ? 16'h7601 : c == 1 ? 16'h4000 : 16'h5200;
      wr(`PMC_OFS_MASK, c == 2 ? 32'h0000_0000 : 32'h0000_0002);
      rd(`PMC_OFS_CAP, d, r);
      check("cap", d, {16'h0000, cap});
      wr(`PMC_OFS_CAP, 32'h0000_FFFF);
      check("cap write resp", br, `PMC_RESP_OKAY);
      rdly = 3;
      rd(`PMC_OFS_CAP, d, r);
      rdly = 0;
      check("cap after write", d, {16'h0000, cap});
      rd(8'h0C, d, r);
      check("unmapped data", d, 32'h0000_0000);
      check("unmapped resp", r, `PMC_RESP_DECERR);
      wr(8'h0C, 32'h0000_0000);
      check("unmapped write", br, `PMC_RESP_DECERR);
      rd(`PMC_OFS_STAT, d, r);
      check("status load", d[1:0], 2'b01);
      for (s = 0; s < 5; s = s + 1) begin
        // case 4 is hot D3 with wake enable off
        wr(`PMC_OFS_CTRL, s == 4 ? 32'h0000_0003 : 32'h0000_0100 + s);
        wake <= 1'b1;
        @(posedge clock);
        wake <= 1'b0;
        repeat (2) @(posedge clock);
        perm = s == 3 || s == 1 && cap[12] || s == 2 && cap[13];
        check("wake pin", wakeN, !perm);
        check("irq", irq, perm && c != 2);
        rd(`PMC_OFS_STAT, d, r);
        check("status wake", d[1], perm);
        check("irq cleared", irq, 1'b0);
        wr(`PMC_OFS_CTRL, 32'h0000_8000);
        check("wake pin clear", wakeN, 1'b1);
      end
      $display("config %0d done", c);
    end
    finish_test;
  end
endmodule
`default_nettype wire
